//--- include/tsc_pkg.sv
package tsc_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int BSR_W = 8;
  localparam int ID_W = 32;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // instruction codes and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
  // arbitrary identification value
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h1234_5001;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] TLR_ONES = 3'h5;
  localparam logic [2:0] ONES_RESET = 3'h0;
  localparam logic [BSR_W-1:0] BSR_RESET = 8'h00;
  localparam logic [ID_W-1:0] ID_SHIFT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TS_RESET = 4'h0,
    TS_IDLE  = 4'h1,
    TS_SELDR = 4'h2,
    TS_CAPDR = 4'h3,
    TS_SHDR  = 4'h4,
    TS_EX1DR = 4'h5,
    TS_PAUDR = 4'h6,
    TS_EX2DR = 4'h7,
    TS_UPDDR = 4'h8,
    TS_SELIR = 4'h9,
    TS_CAPIR = 4'ha,
    TS_SHIR  = 4'hb,
    TS_EX1IR = 4'hc,
    TS_PAUIR = 4'hd,
    TS_EX2IR = 4'he,
    TS_UPDIR = 4'hf
  } tsc_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tsc_pins_s;

  localparam tsc_pins_s PINS_RESET = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

endpackage

//--- verilog/tsc_fifo.sv
`timescale 1ns/1ps
module tsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic inReady_q;
  logic outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic push;
  logic pop;

  // output stage counts as one extra slot beyond the memory
  assign push = inValid && inReady_q;
  assign pop = (cnt_q != '0) && (!outValid_q || outReady);

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
      inReady_q <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + PW'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + PW'(1);
      end
      cnt_q <= cnt_d;
      inReady_q <= (cnt_d != FULL_CNT);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (pop) begin
      outValid_q <= 1'b1;
      outData_q <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outData = outData_q;

endmodule

//--- verilog/tsc_tap_ctrl.sv
`timescale 1ns/1ps
module tsc_tap_ctrl
  import tsc_pkg::*;
#(
  parameter logic [ID_W-1:0] IDCODE_VALUE = ID_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tckPin,
  input wire logic tmsPin,
  input wire logic tdiPin,
  input wire logic [BSR_W-1:0] pinIn,
  input wire logic updReadyIn,
  output logic tdoOut,
  output logic tdoOe,
  output logic [BSR_W-1:0] bsrOut,
  output logic extestEn,
  output tsc_state_e tapState,
  output logic [IR_W-1:0] irCurrent,
  output logic updReady,
  output logic updValid,
  output logic [BSR_W-1:0] updData
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic isBsrIns(input logic [IR_W-1:0] ins);
    isBsrIns = (ins == INS_EXTEST) || (ins == INS_SAMPLE);
  endfunction

  function automatic logic isShift(input tsc_state_e st);
    isShift = (st == TS_SHDR) || (st == TS_SHIR);
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // tck is just another pin here; 160 ns period gives 8 clocks per
  // tck cycle, so edges are seen about three clocks late
  tsc_pins_s sync1_q;
  tsc_pins_s sync2_q;
  tsc_pins_s sync3_q;
  tsc_pins_s filt_q;
  tsc_pins_s filt_d;
  logic tckRise;
  logic tckFall;
  logic tmsNow;
  logic tdiNow;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= PINS_RESET;
      sync2_q <= PINS_RESET;
      sync3_q <= PINS_RESET;
      filt_q <= PINS_RESET;
    end else begin
      sync1_q <= '{tck: tckPin, tms: tmsPin, tdi: tdiPin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  // a change counts once the second and third stages agree
  always_comb begin
    filt_d = filt_q;
    if (sync2_q.tck == sync3_q.tck) begin
      filt_d.tck = sync3_q.tck;
    end
    if (sync2_q.tms == sync3_q.tms) begin
      filt_d.tms = sync3_q.tms;
    end
    if (sync2_q.tdi == sync3_q.tdi) begin
      filt_d.tdi = sync3_q.tdi;
    end
  end

  assign tckRise = filt_d.tck && !filt_q.tck;
  assign tckFall = !filt_d.tck && filt_q.tck;
  assign tmsNow = filt_d.tms;
  assign tdiNow = filt_d.tdi;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  tsc_state_e state_q;
  tsc_state_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TS_RESET: state_d = tmsNow ? TS_RESET : TS_IDLE;
      TS_IDLE: state_d = tmsNow ? TS_SELDR : TS_IDLE;
      TS_SELDR: state_d = tmsNow ? TS_SELIR : TS_CAPDR;
      TS_CAPDR: state_d = tmsNow ? TS_EX1DR : TS_SHDR;
      TS_SHDR: state_d = tmsNow ? TS_EX1DR : TS_SHDR;
      TS_EX1DR: state_d = tmsNow ? TS_UPDDR : TS_PAUDR;
      TS_PAUDR: state_d = tmsNow ? TS_EX2DR : TS_PAUDR;
      TS_EX2DR: state_d = tmsNow ? TS_UPDDR : TS_SHDR;
      TS_UPDDR: state_d = tmsNow ? TS_SELDR : TS_IDLE;
      TS_SELIR: state_d = tmsNow ? TS_RESET : TS_CAPIR;
      TS_CAPIR: state_d = tmsNow ? TS_EX1IR : TS_SHIR;
      TS_SHIR: state_d = tmsNow ? TS_EX1IR : TS_SHIR;
      TS_EX1IR: state_d = tmsNow ? TS_UPDIR : TS_PAUIR;
      TS_PAUIR: state_d = tmsNow ? TS_EX2IR : TS_PAUIR;
      TS_EX2IR: state_d = tmsNow ? TS_UPDIR : TS_SHIR;
      TS_UPDIR: state_d = tmsNow ? TS_SELDR : TS_IDLE;
      default: state_d = TS_RESET;
    endcase
  end

  // async reset puts the machine in reset with no tck activity
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= TS_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [IR_W-1:0] irShift_q;
  logic [IR_W-1:0] irCur_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irShift_q <= IR_CAPTURE;
    end else if (tckRise) begin
      if (state_q == TS_CAPIR) begin
        irShift_q <= IR_CAPTURE;
      end else if (state_q == TS_SHIR) begin
        irShift_q <= {tdiNow, irShift_q[IR_W-1:1]};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irCur_q <= INS_IDCODE;
    end else if (state_q == TS_RESET) begin
      irCur_q <= INS_IDCODE;
    end else if (tckFall && state_q == TS_UPDIR) begin
      irCur_q <= irShift_q;
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  // only capture and shift states touch these, so idle, pause and
  // exit states hold them
  logic bypass_q;
  logic [ID_W-1:0] idShift_q;
  logic [BSR_W-1:0] bsrShift_q;
  logic [BSR_W-1:0] bsrOut_q;
  logic drCapture;
  logic drShift;

  assign drCapture = tckRise && (state_q == TS_CAPDR);
  assign drShift = tckRise && (state_q == TS_SHDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bypass_q <= 1'b0;
      idShift_q <= ID_SHIFT_RESET;
      bsrShift_q <= BSR_RESET;
    end else if (isBsrIns(irCur_q)) begin
      if (drCapture) begin
        bsrShift_q <= pinIn;
      end else if (drShift) begin
        bsrShift_q <= {tdiNow, bsrShift_q[BSR_W-1:1]};
      end
    end else if (irCur_q == INS_IDCODE) begin
      if (drCapture) begin
        idShift_q <= IDCODE_VALUE;
      end else if (drShift) begin
        idShift_q <= {tdiNow, idShift_q[ID_W-1:1]};
      end
    end else if (drShift) begin
      bypass_q <= tdiNow;
    end
  end

  // the latched output moves only on the falling edge in Update-DR
  logic bsrLatch;
  assign bsrLatch = tckFall && (state_q == TS_UPDDR) && isBsrIns(irCur_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bsrOut_q <= BSR_RESET;
    end else if (bsrLatch) begin
      bsrOut_q <= bsrShift_q;
    end
  end

  // test logic only takes the pins under EXTEST, never after reset
  logic extestEn_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extestEn_q <= 1'b0;
    end else begin
      extestEn_q <= (irCur_q == INS_EXTEST);
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic tdoOut_q;
  logic tdoOe_q;
  logic tdoSel;

  always_comb begin
    if (state_q == TS_SHIR) begin
      tdoSel = irShift_q[0];
    end else if (isBsrIns(irCur_q)) begin
      tdoSel = bsrShift_q[0];
    end else if (irCur_q == INS_IDCODE) begin
      tdoSel = idShift_q[0];
    end else begin
      tdoSel = bypass_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdoOut_q <= 1'b0;
      tdoOe_q <= 1'b0;
    end else if (state_q == TS_RESET) begin
      tdoOe_q <= 1'b0;
    end else if (tckFall) begin
      tdoOut_q <= tdoSel;
      tdoOe_q <= isShift(state_q);
    end
  end

  // ----------------------------------------------------------------
  // update stream toward the core
  // ----------------------------------------------------------------
  // the tester cannot be stalled; a word arriving while full is lost
  // and updReady shows that state to the core side
  tsc_fifo #(
    .WIDTH(BSR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .inValid(bsrLatch),
    .inData(bsrShift_q),
    .inReady(updReady),
    .outValid(updValid),
    .outData(updData),
    .outReady(updReadyIn)
  );

  assign tdoOut = tdoOut_q;
  assign tdoOe = tdoOe_q;
  assign bsrOut = bsrOut_q;
  assign extestEn = extestEn_q;
  assign tapState = state_q;
  assign irCurrent = irCur_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] ones_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ones_q <= ONES_RESET;
    end else if (tckRise) begin
      if (!tmsNow) begin
        ones_q <= ONES_RESET;
      end else if (ones_q != TLR_ONES) begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sRise(tsc_state_e st);
    tckRise && (state_q == st);
  endsequence

  sequence sFall(tsc_state_e st);
    tckFall && (state_q == st);
  endsequence

  chk_five_ones: assert property (
    (ones_q == TLR_ONES) |-> (state_q == TS_RESET))
    else $error("five tms highs did not reach reset");

  chk_idle_hold: assert property (
    sRise(TS_IDLE) ##0 !tmsNow |=> (state_q == TS_IDLE) && $stable(irShift_q))
    else $error("idle did not hold");

  chk_sel_dr: assert property (
    sRise(TS_SELDR) |=>
      (state_q == ($past(tmsNow) ? TS_SELIR : TS_CAPDR)))
    else $error("select-dr exit wrong");

  chk_sel_ir: assert property (
    sRise(TS_SELIR) ##0 tmsNow |=> (state_q == TS_RESET))
    else $error("select-ir with tms high did not reset");

  chk_capir_load: assert property (
    sRise(TS_CAPIR) |=> (irShift_q == IR_CAPTURE) && $stable(irCur_q))
    else $error("capture-ir pattern not loaded");

  chk_capdr_pins: assert property (
    sRise(TS_CAPDR) ##0 isBsrIns(irCur_q) |=> bsrShift_q == $past(pinIn))
    else $error("boundary capture missed pins");

  chk_pause_hold: assert property (
    sRise(TS_PAUDR) ##0 !tmsNow |=>
      (state_q == TS_PAUDR) && $stable(bsrShift_q) && $stable(idShift_q))
    else $error("pause-dr did not hold");

  chk_bsr_latch: assert property (
    $changed(bsrOut_q) |-> $past(state_q) == TS_UPDDR && $past(tckFall))
    else $error("boundary output moved outside update");

  chk_ir_update: assert property (
    sFall(TS_UPDIR) |=> irCur_q == $past(irShift_q))
    else $error("instruction not latched in update-ir");

  chk_tdo_drive: assert property (
    tckFall && !isShift(state_q) |=> !tdoOe_q [*2])
    else $error("tdo driven outside shift");

  chk_ir_reset: assert property (
    (state_q == TS_RESET) |=> (irCur_q == INS_IDCODE) && !tdoOe_q)
    else $error("reset state did not restore idcode");

endmodule

//--- sim/tsc_tester_model.sv
`timescale 1ns/1ps
module tsc_tester_model (
  input wire logic ref_clk,
  input wire logic tdoOut,
  input wire logic tdoOe,
  output logic tckPin,
  output logic tmsPin,
  output logic tdiPin
);
  initial begin
    tckPin = 1'b0;
    tmsPin = 1'b1;
    tdiPin = 1'b1;
  end

  // --------------------------------------------------------------
  // one tck period of 8 clocks, entered just after a clock edge
  // --------------------------------------------------------------
  // tck stands low between calls; tms and tdi lead the rise by 2
  task automatic step(input logic m, input logic d, output logic o);
    tmsPin = m;
    tdiPin = d;
    repeat (2) @(posedge ref_clk);
    #1;
    tckPin = 1'b1;
    repeat (3) @(posedge ref_clk);
    // tdo last moved on the previous fall; undriven reads as z
    o = tdoOe ? tdoOut : 1'bz;
    @(posedge ref_clk);
    #1;
    tckPin = 1'b0;
    // released data line shows the inverse, not the old bit
    tdiPin = ~d;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
endmodule

//--- sim/tsc_tap_ctrl_tb.sv
`timescale 1ns/1ps
module tsc_tap_ctrl_tb;
  import tsc_pkg::*;
  logic ref_clk, rst, tckPin, tmsPin, tdiPin, updReadyIn, o;
  logic tdoOut, tdoOe, extestEn, updReady, updValid;
  logic [BSR_W-1:0] pinIn, bsrOut, updData;
  logic [IR_W-1:0] irCurrent;
  logic [31:0] d;
  tsc_state_e tapState;
  int nFail, totalChecks;

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  tsc_tap_ctrl tsc_tap_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
    .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .pinIn(pinIn),
    .updReadyIn(updReadyIn), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .bsrOut(bsrOut), .extestEn(extestEn), .tapState(tapState),
    .irCurrent(irCurrent), .updReady(updReady), .updValid(updValid),
    .updData(updData));
  tsc_tester_model tsc_tester_model_inst (.ref_clk(ref_clk),
    .tdoOut(tdoOut), .tdoOe(tdoOe), .tckPin(tckPin), .tmsPin(tmsPin),
    .tdiPin(tdiPin));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic st(input logic m);
    tsc_tester_model_inst.step(m, 1'b0, o);
  endtask

  // from idle through capture, n shift bits LSB first, update, idle
  task automatic scan(input logic isIr, input int n,
                      input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    st(1'b1);
    if (isIr) begin
      st(1'b1);
    end
    st(1'b0);
    st(1'b0);
    for (int i = 0; i < n; i++) begin
      tsc_tester_model_inst.step(i == n - 1, din[i], dout[i]);
    end
    st(1'b1);
    check("tdoOe off shift", tdoOe, 32'h0);
    st(1'b0);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic tReset();
    check("state", tapState, TS_RESET);
    check("ir", irCurrent, INS_IDCODE);
    check("extestEn", extestEn, 32'h0);
    check("bsrOut", bsrOut, BSR_RESET);
    check("tdoOe", tdoOe, 32'h0);
    check("fifo", {updValid, updReady}, 32'h1);
  endtask

  task automatic tWalk();
    logic [43:0] tmsS;
    logic [175:0] expS;
    tmsS = 44'h225d6ca9ede;
    expS = 176'h11234456674582356781_29abcdebcddef29acf129001;
    for (int i = 0; i < 44; i++) begin
      st(tmsS[43-i]);
      check("walk", tapState, expS[4*(43-i) +: 4]);
    end
  endtask

  task automatic tFive();
    st(1'b0);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    repeat (4) st(1'b1);
    check("four ones", tapState, TS_SELIR);
    st(1'b1);
    check("five ones", tapState, TS_RESET);
    st(1'b1);
    check("held", tapState, TS_RESET);
    check("ir reset", irCurrent, INS_IDCODE);
    st(1'b0);
  endtask

  task automatic tIdcode();
    scan(1'b0, 32, 32'h0, d);
    check("idcode", d, ID_DEFAULT);
  endtask

  task automatic tBoundary();
    pinIn = 8'ha5;
    scan(1'b1, 3, INS_EXTEST, d);
    check("ir capture", d[2:0], IR_CAPTURE);
    check("ir new", irCurrent, INS_EXTEST);
    check("extestEn", extestEn, 32'h1);
    check("bsr before", bsrOut, BSR_RESET);
    scan(1'b0, 8, 32'h3c, d);
    check("bsr capture", d[7:0], 8'ha5);
    check("bsr update", bsrOut, 8'h3c);
    repeat (3) st(1'b0);
    check("idle bsr", bsrOut, 8'h3c);
    check("idle ir", irCurrent, INS_EXTEST);
    check("idle state", tapState, TS_IDLE);
    drain(1);
  endtask

  task automatic drain(input int n);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (updValid !== 1'b1 && k < 20) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      if (updValid !== 1'b1) begin
        nFail++;
        tallyAndFinish();
      end
      check("updData", updData, n == 1 ? 32'h3c : j);
      updReadyIn = 1'b1;
      @(posedge ref_clk);
      #1;
      updReadyIn = 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    #1;
    check("updValid empty", updValid, 32'h0);
  endtask

  task automatic tFifo();
    scan(1'b1, 3, INS_SAMPLE, d);
    check("extestEn sample", extestEn, 32'h0);
    check("ir sample", irCurrent, INS_SAMPLE);
    for (int i = 0; i < 10; i++) begin
      scan(1'b0, 8, i, d);
    end
    check("fifo full", updReady, 32'h0);
    drain(9);
    scan(1'b1, 3, INS_BYPASS, d);
    scan(1'b0, 4, 32'hb, d);
    check("bypass", d[3:1], 3'h3);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pinIn = 8'h00;
    updReadyIn = 1'b0;
    nFail = 0;
    totalChecks = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    tReset();
    tWalk();
    tFive();
    tIdcode();
    tBoundary();
    tFifo();
    tallyAndFinish();
  end

  initial begin
    #1000000;
    nFail++;
    tallyAndFinish();
  end
endmodule
